// File: src/cl_pkg.sv
// Constants for the control-word LED and strap slice.
// Assumes a 20 MHz core clock and synchronous active-high reset.
package cl_pkg;
  localparam int          CLK_MHZ        = 20;
  localparam int          ON_TIME_US     = 5240;
  localparam int          OFF_TIME_US    = 36650;
  localparam int          PERIOD_TIME_US = 41890;
  localparam int          ON_CYCLES      = ON_TIME_US * CLK_MHZ;
  localparam int          OFF_CYCLES     = OFF_TIME_US * CLK_MHZ;
  localparam int          SHORT_SHIFT    = 10;
  localparam int          CNT_W          = 20;
  localparam logic [15:0] IO_BASE_MODE1  = 16'h0200;
  localparam logic [2:0]  FORCED_MODE1   = 3'h1;
  localparam logic [2:0]  FORCED_NONE    = 3'h0;
  localparam int          STRAP_SHORT    = 5;
  localparam logic        LOWPWR_RST_VAL = 1'h0;
  localparam logic        STYLE_RST_VAL  = 1'h0;
  typedef enum logic [1:0] {
    CL_IDLE = 2'h0,
    CL_ON   = 2'h1,
    CL_OFF  = 2'h3
  } cl_blink_t;
endpackage : cl_pkg

// File: src/cl_blink_if.sv
// Link between the control slice and its blink timer.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface cl_blink_if;
  logic blink_req;
  logic short_time;
  logic lamp_on;
  modport ctrl  (output blink_req, output short_time, input lamp_on);
  modport timer (input blink_req, input short_time, output lamp_on);
endinterface : cl_blink_if

// File: src/cl_blinker.sv
// Indicator blink timer: on phase then off phase, repeated while requested.
// Assumes synchronous reset and a request held for the whole activity.
`timescale 1ns/1ps
module cl_blinker import cl_pkg::*; #(
  parameter int ON_CYC  = ON_CYCLES,
  parameter int OFF_CYC = OFF_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control side
  cl_blink_if.timer bl
);
  // Counts must fit the counter width
  if (ON_CYC < 1 || OFF_CYC < 1 || ON_CYC >= (1 << CNT_W) ||
      OFF_CYC >= (1 << CNT_W)) begin : g_bad_counts
    $error("blink counts out of range");
  end

  localparam logic [CNT_W-1:0] ON_L  = CNT_W'(ON_CYC);
  localparam logic [CNT_W-1:0] OFF_L = CNT_W'(OFF_CYC);

  cl_blink_t        state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] on_lim;
  logic [CNT_W-1:0] off_lim;
  logic [CNT_W-1:0] lim;

  always_comb begin
    on_lim  = ON_L;
    off_lim = OFF_L;
    if (bl.short_time) begin
      on_lim  = ON_L >> SHORT_SHIFT;
      off_lim = OFF_L >> SHORT_SHIFT;
    end
    if (on_lim == '0) on_lim = CNT_W'(1);
    if (off_lim == '0) off_lim = CNT_W'(1);
    lim = (state_q == CL_ON) ? on_lim : off_lim;
  end

  always_ff @(posedge clk) begin
    if (reset || !bl.blink_req) begin
      state_q <= CL_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        CL_IDLE: begin
          state_q <= CL_ON;
          cnt_q   <= '0;
        end
        CL_ON, CL_OFF: begin
          // Catch up at once if the limit shrank mid-phase
          if (cnt_q >= lim - CNT_W'(1)) begin
            state_q <= (state_q == CL_ON) ? CL_OFF : CL_ON;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        default: begin
          state_q <= CL_IDLE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  assign bl.lamp_on = (state_q != CL_OFF);

  on_phase_end_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == CL_ON && cnt_q == on_lim - CNT_W'(1) && bl.blink_req)
      |=> (state_q == CL_OFF && cnt_q == '0))
    else $error("on phase did not end at its count");
  off_phase_end_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == CL_OFF && cnt_q == off_lim - CNT_W'(1) && bl.blink_req)
      |=> (state_q == CL_ON && cnt_q == '0))
    else $error("off phase did not end at its count");
  restart_on_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == CL_IDLE && bl.blink_req) |=> (state_q == CL_ON && cnt_q == '0))
    else $error("blink did not restart in on phase");
  short_time_a: assert property (@(posedge clk) disable iff (reset)
    (bl.short_time && $past(bl.short_time) && state_q != CL_IDLE)
      |-> cnt_q < lim)
    else $error("shortcut phase overran its count");
endmodule : cl_blinker

// File: src/cl_ctrl.sv
// Control-word slice: forced setup, low-power reset block, sim shortcut,
// indicator style and the power indicator pin.
// Assumes straps are valid around reset and inputs are core-clock synchronous.
`timescale 1ns/1ps
module cl_ctrl import cl_pkg::*; #(
  parameter int ON_CYC  = ON_CYCLES,
  parameter int OFF_CYC = OFF_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Host reset and power state
  input  wire logic        host_reset_pin_n,
  input  wire logic        d3_state,
  output logic             core_reset,
  // Straps
  input  wire logic [5:0]  strap_data_pins,
  // Software write of the writable bits
  input  wire logic        sw_write,
  input  wire logic        sw_lowpower_reset_block,
  input  wire logic        sw_sim_shortcut,
  input  wire logic        sw_indicator_style,
  // Control bits
  output logic [2:0]       forced_setup_field,
  output logic             lowpower_reset_block,
  output logic             sim_shortcut,
  output logic             indicator_style,
  // Forced setup decode
  output logic [15:0]      cfg_io_base,
  output logic             cfg_io_enable,
  output logic             cfg_mem_enable,
  output logic             cfg_master_enable,
  output logic             cfg_rom_enable,
  output logic             cfg_reserved,
  // Indicator
  input  wire logic        tx_active,
  output logic             power_indicator_pin_n
);
  logic dev_rst;
  logic rst_dly_q;
  logic [2:0] forced_q;
  logic lowpwr_q;
  logic short_q;
  logic style_q;
  // Next values of the registered setup decode
  logic [15:0] io_base_d;
  logic        io_en_d;
  logic        master_d;
  logic        mem_en_d;
  logic        rom_en_d;
  logic        reserved_d;

  // Blink counts must fit the timer counter
  if (ON_CYC < 1 || OFF_CYC < 1 || ON_CYC >= (1 << CNT_W) ||
      OFF_CYC >= (1 << CNT_W)) begin : g_bad_counts
    $error("blink parameters out of range");
  end

  cl_blink_if bl ();

  // Host pin resets unless blocked in D3
  assign dev_rst = reset ||
                   (!host_reset_pin_n && !(lowpwr_q && d3_state));
  assign core_reset = dev_rst;

  always_ff @(posedge clk) begin
    if (reset) rst_dly_q <= 1'h1;
    else       rst_dly_q <= dev_rst;
  end

  // Straps caught on the first edge after reset ends
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      forced_q <= FORCED_NONE;
      short_q  <= 1'h0;
    end else if (rst_dly_q) begin
      forced_q <= ~strap_data_pins[2:0];
      short_q  <= ~strap_data_pins[STRAP_SHORT];
    end else if (sw_write) begin
      short_q  <= sw_sim_shortcut;
    end
  end

  strap_hold_a: assert property (@(posedge clk) disable iff (reset)
    (!dev_rst && !rst_dly_q) |=> $stable(forced_q))
    else $error("forced setup moved after capture");

  // Block bit survives any host reset, cleared only by the reset input or a software write
  always_ff @(posedge clk) begin
    if (reset)                     lowpwr_q <= LOWPWR_RST_VAL;
    else if (sw_write && !dev_rst) lowpwr_q <= sw_lowpower_reset_block;
  end

  lowpwr_keep_a: assert property (@(posedge clk) disable iff (reset)
    dev_rst |=> lowpower_reset_block == $past(lowpower_reset_block))
    else $error("block bit lost on host reset");

  always_ff @(posedge clk) begin
    if (dev_rst)       style_q <= STYLE_RST_VAL;
    else if (sw_write) style_q <= sw_indicator_style;
  end

  soft_write_a: assert property (@(posedge clk) disable iff (reset)
    (sw_write && !dev_rst && !rst_dly_q) |=>
      (indicator_style == $past(sw_indicator_style) &&
       sim_shortcut == $past(sw_sim_shortcut) &&
       lowpower_reset_block == $past(sw_lowpower_reset_block)))
    else $error("software write not taken");

  assign forced_setup_field   = forced_q;
  assign lowpower_reset_block = lowpwr_q;
  assign sim_shortcut         = short_q;
  assign indicator_style      = style_q;

  // Forced mode 1 sets a fixed bring-up; reserved codes enable nothing
  always_comb begin
    io_base_d  = 16'h0000;
    io_en_d    = 1'h0;
    master_d   = 1'h0;
    mem_en_d   = 1'h0;
    rom_en_d   = 1'h0;
    reserved_d = 1'h0;
    case (forced_q)
      FORCED_NONE: begin
        io_base_d = 16'h0000;
      end
      FORCED_MODE1: begin
        io_base_d = IO_BASE_MODE1;
        io_en_d   = 1'h1;
        master_d  = 1'h1;
        mem_en_d  = 1'h0;
        rom_en_d  = 1'h0;
      end
      default: begin
        reserved_d = 1'h1;
      end
    endcase
  end

  // Decode registered one edge behind the setup field
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_io_base       <= 16'h0000;
      cfg_io_enable     <= 1'h0;
      cfg_mem_enable    <= 1'h0;
      cfg_master_enable <= 1'h0;
      cfg_rom_enable    <= 1'h0;
      cfg_reserved      <= 1'h0;
    end else begin
      cfg_io_base       <= io_base_d;
      cfg_io_enable     <= io_en_d;
      cfg_master_enable <= master_d;
      cfg_mem_enable    <= mem_en_d;
      cfg_rom_enable    <= rom_en_d;
      cfg_reserved      <= reserved_d;
    end
  end

  cfg_none_a: assert property (@(posedge clk) disable iff (reset)
    (forced_q == FORCED_NONE) |=> (cfg_io_base == 16'h0000 &&
      !cfg_io_enable && !cfg_master_enable && !cfg_reserved))
    else $error("setup code none enabled access");

  assign bl.blink_req  = tx_active && !style_q;
  assign bl.short_time = short_q;

  cl_blinker #(
    .ON_CYC  (ON_CYC),
    .OFF_CYC (OFF_CYC)
  ) u_blink (
    .clk   (clk),
    .reset (dev_rst),
    .bl    (bl.timer)
  );

  // Low while powered; blinks only in mode 0 during transmit
  always_ff @(posedge clk) begin
    if (dev_rst) power_indicator_pin_n <= 1'h0;
    else power_indicator_pin_n <= bl.blink_req && !bl.lamp_on;
  end

  pin_reset_a: assert property (@(posedge clk) disable iff (reset)
    dev_rst |=> !power_indicator_pin_n)
    else $error("power indicator not low in reset");

  blink_pin_a: assert property (@(posedge clk) disable iff (reset)
    (tx_active && !style_q && !bl.lamp_on && !dev_rst)
      |=> power_indicator_pin_n)
    else $error("power indicator missed off phase");

  lamp_phase_a: assert property (@(posedge clk) disable iff (reset)
    (tx_active && !style_q && bl.lamp_on && !dev_rst)
      |=> !power_indicator_pin_n)
    else $error("power indicator missed on phase");


  forced_mode1_a: assert property (@(posedge clk) disable iff (reset)
    (forced_q == FORCED_MODE1) |=> (cfg_io_base == IO_BASE_MODE1 &&
      cfg_io_enable && cfg_master_enable && !cfg_mem_enable &&
      !cfg_rom_enable))
    else $error("forced mode 1 setup wrong");
  forced_reserved_a: assert property (@(posedge clk) disable iff (reset)
    (forced_q[2] || forced_q[1]) |=> (cfg_reserved && !cfg_io_enable))
    else $error("reserved forced code enabled access");
  reset_block_a: assert property (@(posedge clk) disable iff (reset)
    (!host_reset_pin_n && lowpwr_q && d3_state) |-> !core_reset)
    else $error("blocked host reset reached core");
  host_reset_a: assert property (@(posedge clk)
    (!host_reset_pin_n && !(lowpwr_q && d3_state)) |-> core_reset)
    else $error("host reset not passed to core");
  strap_forced_a: assert property (@(posedge clk) disable iff (reset)
    (rst_dly_q && !dev_rst) |=> forced_q == ~$past(strap_data_pins[2:0]))
    else $error("forced setup not loaded from straps");
  strap_short_a: assert property (@(posedge clk) disable iff (reset)
    (rst_dly_q && !dev_rst) |=> short_q == !$past(strap_data_pins[5]))
    else $error("shortcut not loaded from strap");
  mode1_steady_a: assert property (@(posedge clk) disable iff (dev_rst)
    (style_q && $past(style_q)) |-> !power_indicator_pin_n)
    else $error("mode 1 power indicator not steady low");
  idle_steady_a: assert property (@(posedge clk) disable iff (dev_rst)
    !tx_active ##1 !tx_active |-> !power_indicator_pin_n)
    else $error("power indicator not low while idle");
endmodule : cl_ctrl

// File: testbench/cl_board.sv
// Board model: strap pins and an indicator run-length timer.
// Assumes straps matter only around a core reset; bus traffic after.
`timescale 1ns/1ps
module cl_board (
  // Clock and core reset
  input  wire logic       clk,
  input  wire logic       core_reset,
  // Strap value and pins
  input  wire logic [5:0] strap_val,
  output logic      [5:0] strap_data_pins,
  // Indicator timing
  input  wire logic       pin_n,
  output int              low_len,
  output int              high_len
);
  logic rst_dly_q;
  logic prev_q;
  int   run_q;
  always_ff @(posedge clk) rst_dly_q <= core_reset;
  // Straps held through capture edge, then inverse pattern
  assign strap_data_pins = (core_reset | rst_dly_q) ? strap_val
                                                    : ~strap_val;
  always_ff @(posedge clk) begin
    prev_q <= pin_n;
    if (pin_n == prev_q) run_q <= run_q + 1;
    else begin
      if (prev_q) high_len <= run_q;
      else low_len <= run_q;
      run_q <= 1;
    end
  end
endmodule : cl_board

// File: testbench/tb.sv
// Bench for the control slice: strap table, then hand-written cases.
// Assumes short blink counts and the board model on the far side.
`timescale 1ns/1ps
module tb;
  localparam int ON_C  = 4;
  localparam int OFF_C = 12;
  logic        clk = 0, reset = 1, host_n = 1, d3 = 0, tx = 0;
  logic        sw_w = 0, sw_lp = 0, sw_sim = 0, sw_sty = 0;
  logic [5:0]  strap_val = 6'h3F;
  wire  [5:0]  straps;
  logic        core_rst, lp, sim, sty, io, mem, mst, rom, res, pin_n;
  logic [2:0]  field;
  logic [15:0] base;
  int          low_len, high_len, fail_count, check_count, i, n;
  logic [28:0] rows [5] = '{{6'h3F, 3'h0, 1'h0, 16'h0000, 3'h0},
                            {6'h3E, 3'h1, 1'h0, 16'h0200, 3'h6},
                            {6'h3D, 3'h2, 1'h0, 16'h0000, 3'h1},
                            {6'h3B, 3'h4, 1'h0, 16'h0000, 3'h1},
                            {6'h1F, 3'h0, 1'h1, 16'h0000, 3'h0}};
  always #25 clk = ~clk;
  cl_ctrl #(.ON_CYC(ON_C), .OFF_CYC(OFF_C)) dut_u (
    .clk(clk), .reset(reset), .host_reset_pin_n(host_n), .d3_state(d3),
    .core_reset(core_rst), .strap_data_pins(straps), .sw_write(sw_w),
    .sw_lowpower_reset_block(sw_lp), .sw_sim_shortcut(sw_sim),
    .sw_indicator_style(sw_sty), .forced_setup_field(field),
    .lowpower_reset_block(lp), .sim_shortcut(sim), .indicator_style(sty),
    .cfg_io_base(base), .cfg_io_enable(io), .cfg_mem_enable(mem),
    .cfg_master_enable(mst), .cfg_rom_enable(rom), .cfg_reserved(res),
    .tx_active(tx), .power_indicator_pin_n(pin_n));
  cl_board board_u (.clk(clk), .core_reset(core_rst), .strap_val(strap_val),
    .strap_data_pins(straps), .pin_n(pin_n), .low_len(low_len),
    .high_len(high_len));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask : cyc
  task automatic do_reset();
    reset = 1;
    cyc(2);
    reset = 0;
    cyc(3);
  endtask : do_reset
  task automatic sw_wr(input logic lpv, input logic simv, input logic styv);
    {sw_w, sw_lp, sw_sim, sw_sty} = {1'b1, lpv, simv, styv};
    cyc(1);
    sw_w = 0;
  endtask : sw_wr
  task automatic wait_high();
    n = 0;
    while (pin_n !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n == 100) begin
      fail_count++;
      summarize();
    end
  endtask : wait_high
  initial begin
    for (i = 0; i < 5; i++) begin
      strap_val = rows[i][28:23];
      do_reset();
      chk(field, rows[i][22:20]);
      chk(sim, rows[i][19]);
      chk(base, rows[i][18:3]);
      chk({io, mst, res}, rows[i][2:0]);
      chk({mem, rom, lp, sty}, 4'h0);
    end
    strap_val = 6'h3F;
    do_reset();
    tx = 1;
    wait_high();
    cyc(3 * (ON_C + OFF_C));
    chk(low_len, ON_C);
    chk(high_len, OFF_C);
    tx = 0;
    cyc(2);
    chk(pin_n, 0);
    tx = 1;
    wait_high();
    chk(n, ON_C + 2);
    sw_wr(0, 1, 0);
    chk(sim, 1);
    cyc(20);
    chk({low_len[7:0], high_len[7:0]}, 16'h0101);
    sw_wr(0, 0, 1);
    cyc(2);
    for (i = 0; i < 40; i++) begin
      chk(pin_n, 0);
      cyc(1);
    end
    sw_wr(1, 0, 1);
    {d3, host_n} = 2'b10;
    cyc(1);
    chk(core_rst, 0);
    d3 = 0;
    cyc(1);
    chk(core_rst, 1);
    host_n = 1;
    cyc(3);
    chk({lp, sty}, 2'h2);
    summarize();
  end
endmodule : tb
